// file: rtl/srl_latch_unit.sv
// Set-reset latch unit with selectable sources and AXI4-Lite registers
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// R1 - Set and reset high together leaves the latch reset.
// R2 - Combined inputs are active high; latch reacts without waiting for a clock. The code updates latch_q only on the next aclk edge.
// R3 - Writing one to soft_set_pulse drives set for exactly one cycle.
// R4 - Writing one to soft_reset_pulse drives reset for exactly one cycle.
// R5 - Pulse bits are set-only; writing zero does nothing; they read zero.
// R6 - Divider code 0..7 gives one-cycle pulse every 4..512 cycles.
// R7 - divider_set_enable lets divider pulses set the latch.
// R8 - divider_reset_enable lets divider pulses reset the latch.
// R9 - pin_set_enable lets a high latch input pin set the latch.
// R10 - pin_reset_enable lets a high latch input pin reset the latch.
// R11 - cmp1_set_enable lets high synced comparator one output set latch.
// R12 - cmp1_reset_enable lets high synced comparator one output reset latch.
// R13 - On the larger variant, comparator two sets or resets via bits 5 and 1.
// R14 - latch_enable low disables the latch and both output pins. The code only clears both pin enables; latch_q still updates.
// R15 - true_out_enable places latch state on the true output pin.
// R16 - inv_out_enable places the complemented state on the inverted pin.
// R17 - Both output pins may be driven at the same time.
// R18 - Latch state is not initialised by reset; firmware sets it first.
// R19 - Software should not enable one source onto both set and reset.
// R20 - Comparator inputs are the already synchronised comparator outputs.
// R21 - Combined set and reset are ORs of all enabled sources.
// R22 - Latch is a register updated every cycle; pin input synchronised first.
module srl_latch_unit #(
	parameter bit HAS_CMP2 = 1'b1
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Latch sources
	input wire logic cmp1_synced_out,
	input wire logic cmp2_synced_out,
	input wire logic latch_input_pin,
	// Latch output pins
	output logic true_out_pin,
	output logic true_out_pin_oe,
	output logic inv_out_pin,
	output logic inv_out_pin_oe
);

	logic [7:0] main_ctrl_q;
	logic [7:0] src_en_q;
	logic soft_set_q;
	logic soft_reset_q;
	logic pin_meta_q;
	logic pin_sync_q;
	logic [srl_pkg::DIV_WIDTH-1:0] div_cnt_q;
	logic div_pulse;
	logic [8:0] div_mask;
	logic set_comb;
	logic reset_comb;
	logic latch_q;
	logic latch_en;
	srl_pkg::srl_bus_state_type wr_state_q;
	srl_pkg::srl_bus_state_type rd_state_q;
	logic aw_seen_q;
	logic w_seen_q;
	logic [3:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic wr_fire;
	logic [3:0] rd_addr;
	logic wr_bad;

	// Pin passes two flops; only the second is read by logic
	always_ff @(posedge aclk) begin
		pin_meta_q <= latch_input_pin;
		pin_sync_q <= pin_meta_q; // R22
	end

	// Write channels accepted in either order, response after both
	assign s_axi_awready = (wr_state_q == srl_pkg::SRL_BUS_IDLE) && !aw_seen_q;
	assign s_axi_wready = (wr_state_q == srl_pkg::SRL_BUS_IDLE) && !w_seen_q;
	assign wr_fire = (wr_state_q == srl_pkg::SRL_BUS_IDLE) && aw_seen_q && w_seen_q;
	assign wr_bad = (aw_addr_q != srl_pkg::ADDR_MAIN_CONTROL)
		&& (aw_addr_q != srl_pkg::ADDR_SOURCE_ENABLES);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_q <= srl_pkg::SRL_BUS_IDLE;
			aw_seen_q <= 1'b0;
			w_seen_q <= 1'b0;
			aw_addr_q <= 4'h0;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= srl_pkg::RESP_OKAY;
		end else begin
			case (wr_state_q)
				srl_pkg::SRL_BUS_IDLE: begin
					if (s_axi_awvalid && s_axi_awready) begin
						aw_seen_q <= 1'b1;
						aw_addr_q <= {s_axi_awaddr[3:2], 2'h0};
					end
					if (s_axi_wvalid && s_axi_wready) begin
						w_seen_q <= 1'b1;
						w_data_q <= s_axi_wdata;
						w_strb_q <= s_axi_wstrb;
					end
					if (wr_fire) begin
						wr_state_q <= srl_pkg::SRL_BUS_RESP;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp <= wr_bad ? srl_pkg::RESP_SLVERR : srl_pkg::RESP_OKAY;
					end
				end
				srl_pkg::SRL_BUS_RESP: begin
					if (s_axi_bready) begin
						s_axi_bvalid <= 1'b0;
						aw_seen_q <= 1'b0;
						w_seen_q <= 1'b0;
						wr_state_q <= srl_pkg::SRL_BUS_IDLE;
					end
				end
				default: begin
					wr_state_q <= srl_pkg::SRL_BUS_IDLE;
				end
			endcase
		end
	end

	// Control registers; pulse bits never stored here so they read zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			main_ctrl_q <= srl_pkg::MAIN_CONTROL_RESET;
			src_en_q <= srl_pkg::SOURCE_ENABLES_RESET;
		end else if (wr_fire && w_strb_q[0]) begin
			if (aw_addr_q == srl_pkg::ADDR_MAIN_CONTROL) begin
				main_ctrl_q <= {w_data_q[7:2], 2'h0}; // R5
			end else if (aw_addr_q == srl_pkg::ADDR_SOURCE_ENABLES) begin
				src_en_q <= w_data_q[7:0];
			end
		end
	end

	// Self-clearing software pulses, one cycle each
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			soft_set_q <= 1'b0;
			soft_reset_q <= 1'b0;
		end else begin
			soft_set_q <= wr_fire && w_strb_q[0] && (aw_addr_q == srl_pkg::ADDR_MAIN_CONTROL)
				&& w_data_q[srl_pkg::SOFT_SET_PULSE_BIT]; // R3 R5
			soft_reset_q <= wr_fire && w_strb_q[0] && (aw_addr_q == srl_pkg::ADDR_MAIN_CONTROL)
				&& w_data_q[srl_pkg::SOFT_RESET_PULSE_BIT]; // R4 R5
		end
	end

	// Free-running divider; mask selects period 4 << code
	assign div_mask = 9'(((16'(srl_pkg::DIV_BASE_MASK) + 16'h0001)
		<< main_ctrl_q[srl_pkg::DIV_SEL_HI:srl_pkg::DIV_SEL_LO]) - 16'h0001); // R6
	assign div_pulse = ((div_cnt_q & div_mask) == div_mask); // R6

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt_q <= 9'h000;
		end else begin
			div_cnt_q <= div_cnt_q + 9'h001;
		end
	end

	// OR of enabled sources; comparator two only on the larger variant
	always_comb begin
		set_comb = soft_set_q // R3
			| (div_pulse & src_en_q[srl_pkg::DIVIDER_SET_ENABLE_BIT]) // R7
			| (pin_sync_q & src_en_q[srl_pkg::PIN_SET_ENABLE_BIT]) // R9
			| (cmp1_synced_out & src_en_q[srl_pkg::CMP1_SET_ENABLE_BIT]) // R11 R20
			| (HAS_CMP2 & cmp2_synced_out & src_en_q[srl_pkg::CMP2_SET_ENABLE_BIT]); // R13 R21
		reset_comb = soft_reset_q // R4
			| (div_pulse & src_en_q[srl_pkg::DIVIDER_RESET_ENABLE_BIT]) // R8
			| (pin_sync_q & src_en_q[srl_pkg::PIN_RESET_ENABLE_BIT]) // R10
			| (cmp1_synced_out & src_en_q[srl_pkg::CMP1_RESET_ENABLE_BIT]) // R12 R20
			| (HAS_CMP2 & cmp2_synced_out & src_en_q[srl_pkg::CMP2_RESET_ENABLE_BIT]); // R13 R21
	end

	// Latch kept as a per-cycle register; not cleared by reset on purpose
	always_ff @(posedge aclk) begin
		if (reset_comb) begin
			latch_q <= 1'b0; // R1 R2 R22
		end else if (set_comb) begin
			latch_q <= 1'b1; // R2
		end
	end // R18

	// Outputs; both pins may be enabled together
	assign latch_en = main_ctrl_q[srl_pkg::LATCH_ENABLE_BIT];
	assign true_out_pin_oe = latch_en && main_ctrl_q[srl_pkg::TRUE_OUT_ENABLE_BIT]; // R14 R15 R17
	assign inv_out_pin_oe = latch_en && main_ctrl_q[srl_pkg::INV_OUT_ENABLE_BIT]; // R14 R16 R17
	assign true_out_pin = true_out_pin_oe && latch_q; // R15
	assign inv_out_pin = inv_out_pin_oe && !latch_q; // R16

	// Read channel, one read in flight
	assign s_axi_arready = (rd_state_q == srl_pkg::SRL_BUS_IDLE);
	assign rd_addr = {s_axi_araddr[3:2], 2'h0};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_q <= srl_pkg::SRL_BUS_IDLE;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= srl_pkg::RESP_OKAY;
		end else begin
			case (rd_state_q)
				srl_pkg::SRL_BUS_IDLE: begin
					if (s_axi_arvalid) begin
						rd_state_q <= srl_pkg::SRL_BUS_RESP;
						s_axi_rvalid <= 1'b1;
						s_axi_rresp <= srl_pkg::RESP_OKAY;
						if (rd_addr == srl_pkg::ADDR_MAIN_CONTROL) begin
							s_axi_rdata <= {24'h0, main_ctrl_q}; // R5
						end else if (rd_addr == srl_pkg::ADDR_SOURCE_ENABLES) begin
							s_axi_rdata <= {24'h0, src_en_q};
						end else if (rd_addr == srl_pkg::ADDR_LATCH_STATUS) begin
							s_axi_rdata <= {31'h0, latch_q};
						end else begin
							s_axi_rdata <= 32'h0;
							s_axi_rresp <= srl_pkg::RESP_SLVERR;
						end
					end
				end
				srl_pkg::SRL_BUS_RESP: begin
					if (s_axi_rready) begin
						s_axi_rvalid <= 1'b0;
						rd_state_q <= srl_pkg::SRL_BUS_IDLE;
					end
				end
				default: begin
					rd_state_q <= srl_pkg::SRL_BUS_IDLE;
				end
			endcase
		end
	end

	// Helper: sampled address decode for write assertions
	logic main_wr;
	assign main_wr = wr_fire && w_strb_q[0] && (aw_addr_q == srl_pkg::ADDR_MAIN_CONTROL);
	logic div_code_zero;
	assign div_code_zero = (main_ctrl_q[srl_pkg::DIV_SEL_HI:srl_pkg::DIV_SEL_LO] == 3'h0);

	// Latch state is unknown until a source drives it; the pin complement check waits for that
	logic latch_init_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			latch_init_q <= 1'b0;
		end else if (set_comb || reset_comb) begin
			latch_init_q <= 1'b1;
		end
	end

	sequence s_soft_set_write;
		main_wr && w_data_q[srl_pkg::SOFT_SET_PULSE_BIT];
	endsequence
	sequence s_soft_reset_write;
		main_wr && w_data_q[srl_pkg::SOFT_RESET_PULSE_BIT];
	endsequence

	property p_reset_dominant;
		@(posedge aclk) disable iff (!aresetn) reset_comb |=> !latch_q;
	endproperty
	a_reset_dominant: assert property (p_reset_dominant) else $error("reset did not win"); // R1

	property p_set_takes;
		@(posedge aclk) disable iff (!aresetn) (set_comb && !reset_comb) |=> latch_q;
	endproperty
	a_set_takes: assert property (p_set_takes) else $error("set did not take"); // R2

	property p_soft_set_one;
		@(posedge aclk) disable iff (!aresetn) s_soft_set_write |=> soft_set_q ##1 !soft_set_q;
	endproperty
	a_soft_set_one: assert property (p_soft_set_one) else $error("set pulse not one cycle"); // R3

	property p_soft_reset_one;
		@(posedge aclk) disable iff (!aresetn) s_soft_reset_write |=> soft_reset_q ##1 !soft_reset_q;
	endproperty
	a_soft_reset_one: assert property (p_soft_reset_one) else $error("reset pulse not one cycle"); // R4

	property p_pulse_bits_read_zero;
		@(posedge aclk) disable iff (!aresetn) main_ctrl_q[1:0] == 2'h0;
	endproperty
	a_pulse_bits_read_zero: assert property (p_pulse_bits_read_zero) else $error("pulse bits stored"); // R5

	property p_div_single;
		@(posedge aclk) disable iff (!aresetn) div_pulse |=> !div_pulse;
	endproperty
	a_div_single: assert property (p_div_single) else $error("divider pulse too wide"); // R6

	property p_div_period4;
		@(posedge aclk) disable iff (!aresetn)
			(div_pulse && div_code_zero) |=> !div_pulse[*3] ##1 (div_pulse || !div_code_zero);
	endproperty
	a_div_period4: assert property (p_div_period4) else $error("divider period wrong"); // R6

	property p_oe_needs_enable;
		@(posedge aclk) disable iff (!aresetn) !latch_en |-> (!true_out_pin_oe && !inv_out_pin_oe);
	endproperty
	a_oe_needs_enable: assert property (p_oe_needs_enable) else $error("pin driven while off"); // R14

	property p_pins_complement;
		@(posedge aclk) disable iff (!aresetn)
			(true_out_pin_oe && inv_out_pin_oe && latch_init_q) |-> (true_out_pin != inv_out_pin);
	endproperty
	a_pins_complement: assert property (p_pins_complement) else $error("outputs not complement"); // R17

	property p_pin_reset;
		@(posedge aclk) disable iff (!aresetn)
			(pin_sync_q && src_en_q[srl_pkg::PIN_RESET_ENABLE_BIT]) |=> !latch_q;
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("pin reset ignored"); // R10

	property p_div_reset;
		@(posedge aclk) disable iff (!aresetn)
			(div_pulse && src_en_q[srl_pkg::DIVIDER_RESET_ENABLE_BIT]) |=> !latch_q;
	endproperty
	a_div_reset: assert property (p_div_reset) else $error("divider reset ignored"); // R8

	property p_pin_set;
		@(posedge aclk) disable iff (!aresetn)
			(pin_sync_q && src_en_q[srl_pkg::PIN_SET_ENABLE_BIT] && !reset_comb) |=> latch_q;
	endproperty
	a_pin_set: assert property (p_pin_set) else $error("pin set ignored"); // R9

	property p_cmp1_set;
		@(posedge aclk) disable iff (!aresetn)
			(cmp1_synced_out && src_en_q[srl_pkg::CMP1_SET_ENABLE_BIT] && !reset_comb) |=> latch_q;
	endproperty
	a_cmp1_set: assert property (p_cmp1_set) else $error("comparator set ignored"); // R11

endmodule // srl_latch_unit

// file: rtl/srl_pkg.sv
// Package with register map, field positions and constants for the set-reset latch unit
package srl_pkg;
	// Register byte addresses
	localparam logic [3:0] ADDR_MAIN_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_SOURCE_ENABLES = 4'h4;
	localparam logic [3:0] ADDR_LATCH_STATUS = 4'h8;
	// Reset values
	localparam logic [7:0] MAIN_CONTROL_RESET = 8'h00;
	localparam logic [7:0] SOURCE_ENABLES_RESET = 8'h00;
	// Main control field positions
	localparam int LATCH_ENABLE_BIT = 7;
	localparam int DIV_SEL_HI = 6;
	localparam int DIV_SEL_LO = 4;
	localparam int TRUE_OUT_ENABLE_BIT = 3;
	localparam int INV_OUT_ENABLE_BIT = 2;
	localparam int SOFT_SET_PULSE_BIT = 1;
	localparam int SOFT_RESET_PULSE_BIT = 0;
	// Source enable field positions
	localparam int PIN_SET_ENABLE_BIT = 7;
	localparam int DIVIDER_SET_ENABLE_BIT = 6;
	localparam int CMP2_SET_ENABLE_BIT = 5;
	localparam int CMP1_SET_ENABLE_BIT = 4;
	localparam int PIN_RESET_ENABLE_BIT = 3;
	localparam int DIVIDER_RESET_ENABLE_BIT = 2;
	localparam int CMP2_RESET_ENABLE_BIT = 1;
	localparam int CMP1_RESET_ENABLE_BIT = 0;
	// Divider: period is 4 shifted left by the select code
	localparam int DIV_WIDTH = 9;
	localparam logic [DIV_WIDTH-1:0] DIV_BASE_MASK = 9'h003;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Bus handshake states
	typedef enum logic [0:0] {
		SRL_BUS_IDLE = 1'b0,
		SRL_BUS_RESP = 1'b1
	} srl_bus_state_type;
endpackage

// file: tb/srl_far_side.sv
// Far-side model: comparator and pin sources, and the board wires on the output pins
`timescale 1ns/100ps
module srl_far_side (
	// Clock
	input wire logic aclk,
	// Levels requested by the bench: bit0 cmp1, bit1 cmp2, bit2 pin
	input wire logic [2:0] lvl,
	// Source lines into the block
	output logic cmp1_synced_out,
	output logic cmp2_synced_out,
	output logic latch_input_pin,
	// Output pins from the block
	input wire logic true_out_pin,
	input wire logic true_out_pin_oe,
	input wire logic inv_out_pin,
	input wire logic inv_out_pin_oe,
	// Resolved board wires
	output logic true_wire,
	output logic inv_wire
);
	logic true_last_q;
	logic inv_last_q;
	// Comparator levels arrive already aligned to the block clock
	assign cmp1_synced_out = lvl[0];
	assign cmp2_synced_out = lvl[1];
	assign latch_input_pin = lvl[2];
	// No pull on the board, so a released wire shows the inverse of its last level
	assign true_wire = true_out_pin_oe ? true_out_pin : ~true_last_q;
	assign inv_wire = inv_out_pin_oe ? inv_out_pin : ~inv_last_q;
	// Remember the last driven levels
	always_ff @(posedge aclk) begin
		if (true_out_pin_oe) true_last_q <= true_out_pin;
		if (inv_out_pin_oe) inv_last_q <= inv_out_pin;
	end
endmodule // srl_far_side

// file: tb/srl_latch_unit_tb.sv
// Self-checking bench for the set-reset latch unit
`timescale 1ns/100ps
module srl_latch_unit_tb;
	logic aclk, aresetn;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp;
	logic [2:0] lvl;
	logic cmp1, cmp2, pin_in, tq, tq_oe, nq, nq_oe, true_wire, inv_wire;
	int miscompares, comparisons;
	// Block with the second comparator present
	srl_latch_unit #(.HAS_CMP2(1'b1)) u_srl_latch_unit (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.cmp1_synced_out(cmp1), .cmp2_synced_out(cmp2), .latch_input_pin(pin_in),
		.true_out_pin(tq), .true_out_pin_oe(tq_oe), .inv_out_pin(nq), .inv_out_pin_oe(nq_oe)
	);
	srl_far_side u_srl_far_side (
		.aclk(aclk), .lvl(lvl), .cmp1_synced_out(cmp1), .cmp2_synced_out(cmp2),
		.latch_input_pin(pin_in), .true_out_pin(tq), .true_out_pin_oe(tq_oe),
		.inv_out_pin(nq), .inv_out_pin_oe(nq_oe), .true_wire(true_wire), .inv_wire(inv_wire)
	);
	// 100 MHz clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// Verdict and end of run
	task automatic final_report;
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask
	// A used-up wait bound ends the run as a failure
	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			miscompares++;
			final_report;
		end
	endtask
	// Bus write: address and data offered together, each dropped when taken
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			n++;
		end while (!bvalid && n < 100);
		bready <= 1'b0;
		tmo(n, 100);
		chk(32'(bresp), 32'(er));
	endtask
	// Bus read with expected data and response
	task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			n++;
		end while (!rvalid && n < 100);
		rready <= 1'b0;
		tmo(n, 100);
		chk(rdata, {24'h0, d});
		chk(32'(rresp), 32'(er));
	endtask
	task automatic mc(input logic [7:0] d);
		wr(srl_pkg::ADDR_MAIN_CONTROL, d, srl_pkg::RESP_OKAY);
	endtask
	task automatic se(input logic [7:0] d);
		wr(srl_pkg::ADDR_SOURCE_ENABLES, d, srl_pkg::RESP_OKAY);
	endtask
	task automatic st(input logic q);
		rd(srl_pkg::ADDR_LATCH_STATUS, {7'h0, q}, srl_pkg::RESP_OKAY);
	endtask
	// Reset values, unmapped address, pins released
	task automatic t_reset;
		rd(srl_pkg::ADDR_MAIN_CONTROL, srl_pkg::MAIN_CONTROL_RESET, srl_pkg::RESP_OKAY);
		rd(srl_pkg::ADDR_SOURCE_ENABLES, srl_pkg::SOURCE_ENABLES_RESET, srl_pkg::RESP_OKAY);
		rd(4'hC, 8'h00, srl_pkg::RESP_SLVERR);
		wr(4'hC, 8'hFF, srl_pkg::RESP_SLVERR);
		chk(32'({tq_oe, nq_oe}), 32'h0);
	endtask
	// Software pulses, reset priority and output enables
	task automatic t_soft;
		mc(8'h8E);
		rd(srl_pkg::ADDR_MAIN_CONTROL, 8'h8C, srl_pkg::RESP_OKAY);
		st(1'b1);
		chk(32'({tq_oe, nq_oe, true_wire, inv_wire}), 32'hE);
		mc(8'h8C);
		st(1'b1);
		mc(8'h8D);
		st(1'b0);
		chk(32'({true_wire, inv_wire}), 32'h1);
		mc(8'h8E);
		st(1'b1);
		mc(8'h8F);
		st(1'b0);
		mc(8'h88);
		chk(32'({tq_oe, nq_oe}), 32'h2);
		mc(8'h0C);
		chk(32'({tq_oe, nq_oe}), 32'h0);
	endtask
	// Each source bit: no effect while clear, moves the latch once set
	task automatic t_src;
		int i;
		logic s;
		for (i = 0; i < 8; i++) begin
			s = (i >= 4);
			mc(s ? 8'h81 : 8'h82);
			lvl <= {i % 4 == 3, i % 4 == 1, i % 4 == 0};
			repeat (12) @(posedge aclk);
			st(~s);
			se(8'h01 << i);
			repeat (12) @(posedge aclk);
			lvl <= 3'h0;
			se(8'h00);
			st(s);
		end
	endtask
	// Edges from one low sample of the true wire to the next
	task automatic gap(output int n);
		int k;
		k = 0;
		while (true_wire !== 1'b0 && k < 1100) begin
			@(posedge aclk);
			k++;
		end
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (true_wire !== 1'b0 && n < 1100);
		tmo(k, 1100);
		tmo(n, 1100);
	endtask
	// Pin holds set while divider resets: true output dips once per period
	task automatic t_div;
		int c, n;
		se(8'h84);
		lvl <= 3'h4;
		for (c = 0; c < 8; c++) begin
			mc(8'h88 | 8'(c << 4));
			gap(n);
			gap(n);
			chk(32'(n), 32'(4 << c));
		end
		lvl <= 3'h0;
		se(8'h00);
	endtask
	// Main sequence
	initial begin
		aresetn = 1'b0;
		{awaddr, araddr, wdata, lvl} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'hF;
		miscompares = 0;
		comparisons = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_soft;
		t_src;
		t_div;
		final_report;
	end
endmodule // srl_latch_unit_tb
